// ==== rtl/ssl_pkg.sv ====
package ssl_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_AGREE_RANGE  = 8'h00;
   localparam logic [7:0]  OFS_ZSPD_RANGE   = 8'h04;
   localparam logic [7:0]  OFS_FWD_TRQ      = 8'h08;
   localparam logic [7:0]  OFS_REV_TRQ      = 8'h0C;
   localparam logic [7:0]  OFS_MAXSPD_PS    = 8'h10;
   localparam logic [7:0]  OFS_MAXSPD_TQ    = 8'h14;
   localparam logic [7:0]  OFS_DEV_UNIT     = 8'h18;
   localparam logic [7:0]  OFS_ZDEV_RANGE   = 8'h1C;
   localparam logic [7:0]  OFS_TUNE_MODE    = 8'h20;
   localparam logic [7:0]  OFS_GAIN2        = 8'h24;
   localparam logic [7:0]  OFS_GAIN2_CONF   = 8'h28;
   localparam logic [7:0]  OFS_GAIN2_ADJ    = 8'h2C;
   localparam logic [7:0]  OFS_ET_STROKE    = 8'h30;
   localparam logic [7:0]  OFS_ET_SPEED     = 8'h34;
   localparam logic [7:0]  OFS_ET_DWELL     = 8'h38;
   localparam logic [7:0]  OFS_ET_DIR       = 8'h3C;
   localparam logic [7:0]  OFS_STATUS       = 8'h40;

   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [31:0] RANGE_RST        = 32'h0000_0032;
   localparam logic [31:0] RANGE_MIN        = 32'h0000_000A;
   localparam logic [31:0] TRQ_RST          = 32'h0000_012C;
   localparam logic [31:0] TRQ_MAX          = 32'h0000_012C;
   localparam logic [31:0] MAXSPD_RST       = 32'h0004_93E0;
   localparam logic [31:0] ZDEV_RST         = 32'h0000_0064;
   localparam logic [31:0] ZDEV_MAX         = 32'h0003_0D40;
   localparam logic [31:0] TMODE_RST        = 32'h0000_000A;
   localparam logic [4:0]  TMODE_AUTO       = 5'h0A;
   localparam logic [4:0]  TMODE_SEMI       = 5'h0B;
   localparam logic [4:0]  TMODE_SHORT      = 5'h0F;
   localparam logic [31:0] GAIN2_RST        = 32'h0000_0004;
   localparam logic [31:0] GAIN2_MIN        = 32'h0000_0001;
   localparam logic [31:0] GAIN2_MAX        = 32'h0000_000C;
   localparam logic [31:0] STROKE_RST       = 32'h0000_00C8;
   localparam logic [31:0] STROKE_MIN       = 32'h0000_0001;
   localparam logic [31:0] STROKE_MAX       = 32'h0000_4E20;
   localparam logic [31:0] ETSPD_RST        = 32'h0000_C350;
   localparam logic [31:0] ETSPD_MIN        = 32'h0000_03E8;
   localparam logic [31:0] DWELL_RST        = 32'h0000_05DC;
   localparam logic [31:0] DWELL_MAX        = 32'h0000_1388;
   localparam logic [1:0]  DIR_ALT          = 2'h0;
   localparam logic [1:0]  DIR_FWD          = 2'h1;
   localparam logic [1:0]  DIR_REV          = 2'h2;
   // speeds are carried in 0.01 r/min, ranges in r/min
   localparam logic [31:0] SPEED_SCALE      = 32'h0000_0064;

   // ----------------------------------------------------------------
   // status register bit positions
   // ----------------------------------------------------------------
   localparam int          ST_AGREE         = 0;
   localparam int          ST_ZSPD          = 1;
   localparam int          ST_ZDEV          = 2;
   localparam int          ST_GAIN2_ON      = 3;
   localparam int          ST_FWD_RUN       = 4;
   localparam int          ST_REV_RUN       = 5;
   localparam int          ST_TSEL          = 6;

   typedef enum logic [1:0] {MODE_POS, MODE_SPD, MODE_TRQ} ssl_mode_t;
endpackage

// ==== rtl/ssl_cfg_if.sv ====
`timescale 1ns/1ps
interface ssl_cfg_if;
   import ssl_pkg::*;
   logic [31:0] agree_range;
   logic [31:0] zspd_range;
   logic [31:0] maxspd_ps;
   logic [31:0] maxspd_tq;
   logic        dev_unit_sel;
   logic [31:0] zdev_range;
   ssl_mode_t   ctrl_mode;
   logic        pulse_op;
   modport src (output agree_range, zspd_range, maxspd_ps, maxspd_tq, dev_unit_sel,
                output zdev_range, ctrl_mode, pulse_op);
   modport cmp (input agree_range, zspd_range, maxspd_ps, maxspd_tq, dev_unit_sel,
                input zdev_range, ctrl_mode, pulse_op);
endinterface

// ==== rtl/ssl_cmp.sv ====
`timescale 1ns/1ps
module ssl_cmp (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               ce,
   ssl_cfg_if.cmp                  cfg,
   input  wire logic signed [31:0] act_speed,
   input  wire logic signed [31:0] cmd_speed,
   input  wire logic               run_any,
   input  wire logic               override_active,
   input  wire logic signed [31:0] dev_unit,
   input  wire logic signed [31:0] dev_pulse,
   output logic                    agree_r,
   output logic                    zspd_r,
   output logic                    zdev_r,
   output logic signed [31:0]      dev_report_r,
   output logic [31:0]             spd_limit_r,
   output logic                    spd_limit_en_r
);
   import ssl_pkg::*;

   // ----------------------------------------------------------------
   // magnitudes and windows
   // ----------------------------------------------------------------
   logic signed [32:0] diff;
   logic [32:0]        diff_mag;
   logic [32:0]        act_mag;
   logic [32:0]        cmd_mag;
   logic [32:0]        dev_mag;
   logic signed [31:0] dev_sel;
   logic [31:0]        lim;
   logic               lim_hit;

   always_comb begin
      diff     = {act_speed[31], act_speed} - {cmd_speed[31], cmd_speed};
      diff_mag = diff[32] ? 33'(-diff) : 33'(diff);
      act_mag  = act_speed[31] ? 33'(-{1'b1, act_speed}) : {1'b0, act_speed};
      cmd_mag  = cmd_speed[31] ? 33'(-{1'b1, cmd_speed}) : {1'b0, cmd_speed};
      dev_sel  = cfg.dev_unit_sel ? dev_pulse : dev_unit;
      dev_mag  = dev_sel[31] ? 33'(-{1'b1, dev_sel}) : {1'b0, dev_sel};
      lim      = (cfg.ctrl_mode == MODE_TRQ) ? cfg.maxspd_tq : cfg.maxspd_ps;
      lim_hit  = !cfg.pulse_op && (cmd_mag > {1'b0, lim});
   end

   // ----------------------------------------------------------------
   // status outputs, re-evaluated every enabled cycle
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         agree_r        <= 1'b0;
         zspd_r         <= 1'b0;
         zdev_r         <= 1'b0;
         dev_report_r   <= 32'sh0000_0000;
         spd_limit_r    <= MAXSPD_RST;
         spd_limit_en_r <= 1'b1;
      end else if (ce) begin
         agree_r        <= run_any
                           && !lim_hit && !override_active
                           && (diff_mag <= {1'b0, cfg.agree_range * SPEED_SCALE});
         zspd_r         <= act_mag <= {1'b0, cfg.zspd_range * SPEED_SCALE};
         zdev_r         <= dev_mag <= {1'b0, cfg.zdev_range};
         dev_report_r   <= dev_sel;
         spd_limit_r    <= lim;
         spd_limit_en_r <= !cfg.pulse_op;
      end
   end
endmodule

// ==== rtl/ssl_top.sv ====
`timescale 1ns/1ps
module ssl_top (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               ce,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic signed [31:0] act_speed,
   input  wire logic signed [31:0] cmd_speed,
   input  wire logic               forward_run_cmd,
   input  wire logic               reverse_run_cmd,
   input  wire logic [1:0]         torque_lim_sel,
   input  wire logic [8:0]         torque_lim_alt,
   input  wire ssl_pkg::ssl_mode_t ctrl_mode,
   input  wire logic               pulse_train_op,
   input  wire logic               override_active,
   input  wire logic signed [31:0] dev_unit,
   input  wire logic signed [31:0] dev_pulse,
   output logic                    speed_agree_out,
   output logic                    zero_speed_out,
   output logic                    zero_dev_out,
   output logic signed [31:0]      deviation_out,
   output logic signed [31:0]      analog_dev1_out,
   output logic signed [31:0]      analog_dev2_out,
   output logic [8:0]              fwd_torque_lim_out,
   output logic [8:0]              rev_torque_lim_out,
   output logic [31:0]             speed_limit_out,
   output logic                    speed_limit_en_out,
   output logic [3:0]              gain2_out,
   output logic                    gain2_active_out,
   output logic [15:0]             et_stroke_out,
   output logic [31:0]             et_speed_out,
   output logic [12:0]             et_dwell_out,
   output logic                    et_fwd_en_out,
   output logic                    et_rev_en_out,
   output logic                    et_alternate_out
);
   import ssl_pkg::*;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [31:0] agree_range_r;
   logic [31:0] zspd_range_r;
   logic [8:0]  fwd_trq_r;
   logic [8:0]  rev_trq_r;
   logic [31:0] maxspd_ps_r;
   logic [31:0] maxspd_tq_r;
   logic        dev_unit_sel_r;
   logic [31:0] zdev_range_r;
   logic [4:0]  tune_mode_r;
   logic [3:0]  gain2_pend_r;
   logic [3:0]  gain2_act_r;
   logic [15:0] et_stroke_r;
   logic [31:0] et_speed_r;
   logic [12:0] et_dwell_r;
   logic [1:0]  et_dir_r;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0]  pin_meta_r;
   logic [3:0]  pin_sync_r;
   logic        run_fwd;
   logic        run_rev;
   logic        tsel_any;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else if (ce) begin
         pin_meta_r <= {torque_lim_sel, reverse_run_cmd, forward_run_cmd};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign run_fwd  = pin_sync_r[0];
   assign run_rev  = pin_sync_r[1];
   assign tsel_any = |pin_sync_r[3:2];

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   logic        wr_pend_r;
   logic [7:0]  wr_ofs_r;
   logic [31:0] hrdata_r;
   logic        addr_ok;
   logic        acc_valid;
   logic        we;
   logic [31:0] status;

   function automatic logic [31:0] clampu(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
      logic [31:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   assign addr_ok   = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
   assign acc_valid = hsel && htrans[1] && hready && ce;
   assign we        = wr_pend_r && ce;
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_ofs_r  <= 8'h00;
      end else if (ce) begin
         wr_pend_r <= acc_valid && hwrite && addr_ok;
         wr_ofs_r  <= haddr[7:0];
      end
   end

   always_comb begin
      status              = 32'h0000_0000;
      status[ST_AGREE]    = speed_agree_out;
      status[ST_ZSPD]     = zero_speed_out;
      status[ST_ZDEV]     = zero_dev_out;
      status[ST_GAIN2_ON] = gain2_active_out;
      status[ST_FWD_RUN]  = run_fwd;
      status[ST_REV_RUN]  = run_rev;
      status[ST_TSEL]     = tsel_any;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (ce) begin
         hrdata_r <= 32'h0000_0000;
         if (acc_valid && !hwrite && addr_ok) begin
            case (haddr[7:0])
               OFS_AGREE_RANGE: hrdata_r <= agree_range_r;
               OFS_ZSPD_RANGE:  hrdata_r <= zspd_range_r;
               OFS_FWD_TRQ:     hrdata_r <= {23'h00_0000, fwd_trq_r};
               OFS_REV_TRQ:     hrdata_r <= {23'h00_0000, rev_trq_r};
               OFS_MAXSPD_PS:   hrdata_r <= maxspd_ps_r;
               OFS_MAXSPD_TQ:   hrdata_r <= maxspd_tq_r;
               OFS_DEV_UNIT:    hrdata_r <= {31'h0000_0000, dev_unit_sel_r};
               OFS_ZDEV_RANGE:  hrdata_r <= zdev_range_r;
               OFS_TUNE_MODE:   hrdata_r <= {27'h000_0000, tune_mode_r};
               OFS_GAIN2:       hrdata_r <= {28'h000_0000, gain2_pend_r};
               OFS_GAIN2_CONF:  hrdata_r <= {28'h000_0000, gain2_act_r};
               OFS_GAIN2_ADJ:   hrdata_r <= {28'h000_0000, gain2_act_r};
               OFS_ET_STROKE:   hrdata_r <= {16'h0000, et_stroke_r};
               OFS_ET_SPEED:    hrdata_r <= et_speed_r;
               OFS_ET_DWELL:    hrdata_r <= {19'h0_0000, et_dwell_r};
               OFS_ET_DIR:      hrdata_r <= {30'h0000_0000, et_dir_r};
               OFS_STATUS:      hrdata_r <= status;
               default:         hrdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // status comparison settings
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         agree_range_r  <= RANGE_RST;
         zspd_range_r   <= RANGE_RST;
         dev_unit_sel_r <= 1'b0;
         zdev_range_r   <= ZDEV_RST;
      end else if (we) begin
         if (wr_ofs_r == OFS_AGREE_RANGE) begin
            agree_range_r <= clampu(hwdata, RANGE_MIN, maxspd_ps_r);
         end
         if (wr_ofs_r == OFS_ZSPD_RANGE) begin
            zspd_range_r <= clampu(hwdata, RANGE_MIN, maxspd_ps_r);
         end
         if (wr_ofs_r == OFS_DEV_UNIT) begin
            dev_unit_sel_r <= hwdata[0];
         end
         if (wr_ofs_r == OFS_ZDEV_RANGE) begin
            zdev_range_r <= clampu(hwdata, 32'h0000_0000, ZDEV_MAX);
         end
      end
   end

   // ----------------------------------------------------------------
   // torque and speed limits
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_trq_r   <= TRQ_RST[8:0];
         rev_trq_r   <= TRQ_RST[8:0];
         maxspd_ps_r <= MAXSPD_RST;
         maxspd_tq_r <= MAXSPD_RST;
      end else if (we) begin
         if (wr_ofs_r == OFS_FWD_TRQ) begin
            fwd_trq_r <= 9'(clampu(hwdata, 32'h0000_0000, TRQ_MAX));
         end
         if (wr_ofs_r == OFS_REV_TRQ) begin
            rev_trq_r <= 9'(clampu(hwdata, 32'h0000_0000, TRQ_MAX));
         end
         if (wr_ofs_r == OFS_MAXSPD_PS) begin
            maxspd_ps_r <= hwdata;
         end
         if (wr_ofs_r == OFS_MAXSPD_TQ) begin
            maxspd_tq_r <= hwdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwd_torque_lim_out <= TRQ_RST[8:0];
         rev_torque_lim_out <= TRQ_RST[8:0];
      end else if (ce) begin
         fwd_torque_lim_out <= tsel_any ? torque_lim_alt : fwd_trq_r;
         rev_torque_lim_out <= tsel_any ? torque_lim_alt : rev_trq_r;
      end
   end

   // ----------------------------------------------------------------
   // tuning gain: staged edit versus immediate adjust
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tune_mode_r  <= TMODE_RST[4:0];
         gain2_pend_r <= GAIN2_RST[3:0];
         gain2_act_r  <= GAIN2_RST[3:0];
      end else if (we) begin
         if (wr_ofs_r == OFS_TUNE_MODE) begin
            tune_mode_r <= hwdata[4:0];
         end
         if (wr_ofs_r == OFS_GAIN2) begin
            gain2_pend_r <= 4'(clampu(hwdata, GAIN2_MIN, GAIN2_MAX));
         end
         if (wr_ofs_r == OFS_GAIN2_CONF) begin
            gain2_act_r <= gain2_pend_r;
         end else if (wr_ofs_r == OFS_GAIN2_ADJ) begin
            gain2_act_r <= 4'(clampu(hwdata, GAIN2_MIN, GAIN2_MAX));
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gain2_active_out <= 1'b0;
         gain2_out        <= 4'h0;
      end else if (ce) begin
         gain2_active_out <= (ctrl_mode == MODE_POS)
                             && (tune_mode_r == TMODE_AUTO || tune_mode_r == TMODE_SEMI
                                 || tune_mode_r == TMODE_SHORT);
         gain2_out        <= gain2_act_r;
      end
   end

   // ----------------------------------------------------------------
   // easy tuning settings
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         et_stroke_r <= STROKE_RST[15:0];
         et_speed_r  <= ETSPD_RST;
         et_dwell_r  <= DWELL_RST[12:0];
         et_dir_r    <= DIR_ALT;
      end else if (we) begin
         if (wr_ofs_r == OFS_ET_STROKE) begin
            et_stroke_r <= 16'(clampu(hwdata, STROKE_MIN, STROKE_MAX));
         end
         if (wr_ofs_r == OFS_ET_SPEED) begin
            et_speed_r <= clampu(hwdata, ETSPD_MIN, maxspd_ps_r);
         end
         if (wr_ofs_r == OFS_ET_DWELL) begin
            et_dwell_r <= 13'(clampu(hwdata, 32'h0000_0000, DWELL_MAX));
         end
         if (wr_ofs_r == OFS_ET_DIR && hwdata[1:0] <= DIR_REV) begin
            et_dir_r <= hwdata[1:0];
         end
      end
   end

   assign et_stroke_out    = et_stroke_r;
   assign et_speed_out     = et_speed_r;
   assign et_dwell_out     = et_dwell_r;
   assign et_alternate_out = (et_dir_r == DIR_ALT);
   assign et_fwd_en_out    = (et_dir_r != DIR_REV);
   assign et_rev_en_out    = (et_dir_r != DIR_FWD);

   // ----------------------------------------------------------------
   // comparison engine
   // ----------------------------------------------------------------
   ssl_cfg_if cfg_if ();

   assign cfg_if.agree_range  = agree_range_r;
   assign cfg_if.zspd_range   = zspd_range_r;
   assign cfg_if.maxspd_ps    = maxspd_ps_r;
   assign cfg_if.maxspd_tq    = maxspd_tq_r;
   assign cfg_if.dev_unit_sel = dev_unit_sel_r;
   assign cfg_if.zdev_range   = zdev_range_r;
   assign cfg_if.ctrl_mode    = ctrl_mode;
   assign cfg_if.pulse_op     = pulse_train_op;

   logic signed [31:0] dev_report;

   ssl_cmp u_cmp (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .ce              (ce),
      .cfg             (cfg_if.cmp),
      .act_speed       (act_speed),
      .cmd_speed       (cmd_speed),
      .run_any         (run_fwd || run_rev),
      .override_active (override_active),
      .dev_unit        (dev_unit),
      .dev_pulse       (dev_pulse),
      .agree_r         (speed_agree_out),
      .zspd_r          (zero_speed_out),
      .zdev_r          (zero_dev_out),
      .dev_report_r    (dev_report),
      .spd_limit_r     (speed_limit_out),
      .spd_limit_en_r  (speed_limit_en_out)
   );

   // every deviation monitor shows the same selected unit
   assign deviation_out   = dev_report;
   assign analog_dev1_out = dev_report;
   assign analog_dev2_out = dev_report;
endmodule

// ==== tb/ssl_host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// host side: latches drive status each clock
// ---------------------------------------------
module ssl_host_model (
   input  wire logic       hclk,
   input  wire logic       agree,
   input  wire logic       zspd,
   input  wire logic       zdev,
   output logic [2:0]      seen_r
);
   always_ff @(posedge hclk) begin
      seen_r <= {zdev, zspd, agree};
   end
endmodule

// ==== tb/ssl_checker.sv ====
`timescale 1ns/1ps
module ssl_checker
   import ssl_pkg::*;
(
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hresp,
   input wire logic               forward_run_cmd,
   input wire logic               reverse_run_cmd,
   input wire logic               override_active,
   input wire logic               pulse_train_op,
   input wire ssl_mode_t          ctrl_mode,
   input wire logic               speed_agree_out,
   input wire logic               speed_limit_en_out,
   input wire logic signed [31:0] deviation_out,
   input wire logic signed [31:0] analog_dev1_out,
   input wire logic signed [31:0] analog_dev2_out,
   input wire logic signed [31:0] dev_unit,
   input wire logic signed [31:0] dev_pulse,
   input wire logic               gain2_active_out,
   input wire logic               et_alternate_out,
   input wire logic               et_fwd_en_out,
   input wire logic               et_rev_en_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_norun; (!forward_run_cmd && !reverse_run_cmd)[*4] |=> !speed_agree_out; endproperty
   a_norun: assert property (p_norun) else $error("agree without run");
   property p_ovr; override_active |=> !speed_agree_out; endproperty
   a_ovr: assert property (p_ovr) else $error("agree under override");
   property p_dev1;
      analog_dev1_out == $past(dev_unit) || analog_dev1_out == $past(dev_pulse);
   endproperty
   a_dev1: assert property (p_dev1) else $error("monitor 1 unit differs");
   property p_dev2; deviation_out == analog_dev2_out; endproperty
   a_dev2: assert property (p_dev2) else $error("monitor 2 unit differs");
   property p_pulse; pulse_train_op |=> !speed_limit_en_out; endproperty
   a_pulse: assert property (p_pulse) else $error("limit on in pulse op");
   property p_gain; ctrl_mode != MODE_POS |=> !gain2_active_out; endproperty
   a_gain: assert property (p_gain) else $error("gain2 outside position");
   property p_dir1; !et_alternate_out |-> et_fwd_en_out != et_rev_en_out; endproperty
   a_dir1: assert property (p_dir1) else $error("one-way direction wrong");
   property p_dir2; et_alternate_out |-> et_fwd_en_out && et_rev_en_out; endproperty
   a_dir2: assert property (p_dir2) else $error("alternate direction wrong");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   cover property (speed_agree_out);
   cover property (gain2_active_out);
   cover property (!et_alternate_out && et_rev_en_out);
endmodule
bind ssl_top ssl_checker u_chk (.hclk, .hresetn, .hresp, .forward_run_cmd, .reverse_run_cmd,
   .override_active, .pulse_train_op, .ctrl_mode, .speed_agree_out, .speed_limit_en_out,
   .deviation_out, .analog_dev1_out, .analog_dev2_out, .gain2_active_out,
   .et_alternate_out, .et_fwd_en_out, .et_rev_en_out, .dev_unit, .dev_pulse);

// ==== tb/test_servo_status_limit_compare.sv ====
`timescale 1ns/1ps
module test_servo_status_limit_compare;
   import ssl_pkg::*;
   logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, zero_dev_out;
   logic               forward_run_cmd = 0, reverse_run_cmd = 0, pulse_train_op = 0;
   logic               override_active = 0, speed_agree_out, zero_speed_out, speed_limit_en_out;
   logic               gain2_active_out, et_fwd_en_out, et_rev_en_out, et_alternate_out;
   logic [1:0]         htrans = 0, torque_lim_sel = 0;
   logic [8:0]         torque_lim_alt = 0, fwd_torque_lim_out, rev_torque_lim_out;
   logic [31:0]        haddr = 0, hwdata = 0, hrdata, rq;
   logic [3:0]         gain2_out;
   logic [31:0]        speed_limit_out, et_speed_out;
   logic [15:0]        et_stroke_out;
   logic [12:0]        et_dwell_out;
   logic [2:0]         seen;
   logic signed [31:0] act_speed = 0, cmd_speed = 0, dev_unit = 0, dev_pulse = 0, deviation_out;
   ssl_mode_t          ctrl_mode = MODE_POS;
   int                 err_count = 0, checked = 0;
   logic [4:0]         tm [4] = '{5'h0A, 5'h0B, 5'h0F, 5'h0C};
   logic [2:0]         dx [4] = '{3'h7, 3'h2, 3'h1, 3'h1};
   ssl_top DUT (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .act_speed, .cmd_speed,
      .forward_run_cmd, .reverse_run_cmd, .torque_lim_sel, .torque_lim_alt, .ctrl_mode,
      .pulse_train_op, .override_active, .dev_unit, .dev_pulse, .speed_agree_out,
      .zero_speed_out, .zero_dev_out, .deviation_out, .analog_dev1_out(), .analog_dev2_out(),
      .fwd_torque_lim_out, .rev_torque_lim_out, .speed_limit_out, .speed_limit_en_out,
      .gain2_out, .gain2_active_out, .et_stroke_out, .et_speed_out, .et_dwell_out,
      .et_fwd_en_out, .et_rev_en_out, .et_alternate_out);
   ssl_host_model HOST (.hclk, .agree(speed_agree_out), .zspd(zero_speed_out),
      .zdev(zero_dev_out), .seen_r(seen));
   always #2.5 hclk = ~hclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rq = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(rq, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
      repeat (5) @(posedge hclk);
   endtask
   task automatic sp(input logic signed [31:0] a, input logic signed [31:0] c, input logic [2:0] e);
      act_speed <= a;
      cmd_speed <= c;
      wr(8'h80, 32'h0);
      chk(seen, e);
   endtask
   task automatic tally_and_finish;
      $display("checked %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(OFS_AGREE_RANGE, RANGE_RST);
      rd(OFS_ZDEV_RANGE, ZDEV_RST);
      rd(OFS_ET_STROKE, STROKE_RST);
      chk(speed_limit_out, MAXSPD_RST);
      chk(et_stroke_out, STROKE_RST);
      chk(et_dwell_out, DWELL_RST);
      chk(et_speed_out, ETSPD_RST);
      rd(8'h80, 32'h0);
      sp(32'sh0001_86A0, 32'sh0001_86A0, 3'h4);
      forward_run_cmd <= 1'b1;
      sp(32'sh0001_9A28, 32'sh0001_86A0, 3'h5);
      sp(32'sh0001_9A29, 32'sh0001_86A0, 3'h4);
      sp(32'sh0005_5730, 32'sh0005_5730, 3'h4);
      override_active <= 1'b1;
      sp(32'sh0001_86A0, 32'sh0001_86A0, 3'h4);
      override_active <= 1'b0;
      sp(-32'sh1388, -32'sh1388, 3'h7);
      dev_unit <= 32'sh64;
      dev_pulse <= 32'sh65;
      sp(-32'sh1389, -32'sh1389, 3'h5);
      chk(deviation_out, 32'h64);
      wr(OFS_DEV_UNIT, 32'h1);
      chk(seen, 3'h1);
      chk(deviation_out, 32'h65);
      wr(OFS_FWD_TRQ, 32'h190);
      rd(OFS_FWD_TRQ, TRQ_MAX);
      wr(OFS_REV_TRQ, 32'h0);
      chk(rev_torque_lim_out, 32'h0);
      torque_lim_sel <= 2'h2;
      torque_lim_alt <= 9'h04D;
      pulse_train_op <= 1'b1;
      wr(8'h80, 32'h0);
      chk(fwd_torque_lim_out, 32'h4D);
      chk(speed_limit_en_out, 32'h0);
      wr(OFS_GAIN2_ADJ, 32'h9);
      chk(gain2_out, 32'h9);
      wr(OFS_GAIN2, 32'h7);
      chk(gain2_out, 32'h9);
      wr(OFS_GAIN2_CONF, 32'h0);
      chk(gain2_out, 32'h7);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_TUNE_MODE, {27'h0, tm[i]});
         chk(gain2_active_out, {31'h0, i < 3});
         wr(OFS_ET_DIR, i);
         chk({et_alternate_out, et_fwd_en_out, et_rev_en_out}, dx[i]);
      end
      ctrl_mode <= MODE_SPD;
      wr(OFS_TUNE_MODE, 32'hA);
      chk(gain2_active_out, 32'h0);
      ctrl_mode <= MODE_TRQ;
      wr(OFS_MAXSPD_TQ, 32'h0003_0D40);
      chk(speed_limit_out, 32'h0003_0D40);
      tally_and_finish;
   end
endmodule
